// >>> rtl/pin_mux_pkg.sv
// constants and types shared by the port pin and external bus multiplexer
// Behaviour
// - port 0 open-drain, latched one floats
// - port 0 drives address/data strongly on bus
// - ports 1-3 pull latched ones high
// - port 2 drives high address on bus
// - 8-bit indirect data keeps port 2 latch
// - 23-bit: A16-22 with strobe high, A8-14 low
// - 23-bit: port 2 bit 7 holds A15
// - spi enable: bit 4 is mosi, no pull-up
// - spi enable: bit 5 is spi clock, no pull-up
// - port 1 bits 0,1 serve timer 2
// - port 1 bits 2-7 serve counter array
// - sequencing uses six-clock machine cycles
// - strobe every machine cycle, skipped on data
// - aux bit 0 limits strobe to ext instructions
package pin_mux_pkg;

  // machine cycle timing
  localparam int unsigned   MC_CLOCKS      = 6;
  localparam logic [2:0]    PHASE_LAST     = 3'h5;
  localparam logic [2:0]    PHASE_RESET    = 3'h0;
  localparam logic [2:0]    ALE_LAST_PHASE = 3'h1;

  // widths
  localparam int unsigned   PORT_W         = 8;
  localparam int unsigned   ADDR_W         = 23;
  localparam int unsigned   PIN_TOTAL      = 32;

  // values after reset and for full drive
  localparam logic [7:0]    PORT_RESET     = 8'hFF;
  localparam logic [7:0]    DRIVE_NONE     = 8'h00;
  localparam logic [7:0]    DRIVE_ALL      = 8'hFF;

  // control bit positions
  localparam int unsigned   SPI_EN_BIT     = 6;
  localparam int unsigned   ALE_OFF_BIT    = 0;

  // port 1 alternate bit positions
  localparam int unsigned   T2_BIT         = 0;
  localparam int unsigned   T2AUX_BIT      = 1;
  localparam int unsigned   ECI_BIT        = 2;
  localparam int unsigned   PCA_BASE_BIT   = 3;
  localparam int unsigned   PCA_MODULES    = 5;
  localparam int unsigned   MOSI_BIT       = 4;
  localparam int unsigned   SCK_BIT        = 5;

  // port 3 alternate bit positions
  localparam int unsigned   RX0_BIT        = 0;
  localparam int unsigned   TX0_BIT        = 1;
  localparam int unsigned   IRQ0_BIT       = 2;
  localparam int unsigned   IRQ1_BIT       = 3;

  // port slices within the synchronised pin vector
  localparam int unsigned   P0_LSB         = 0;
  localparam int unsigned   P1_LSB         = 8;
  localparam int unsigned   P2_LSB         = 16;
  localparam int unsigned   P3_LSB         = 24;

  // kind of external access requested by the core
  typedef enum logic [1:0] {
    ACC_CODE,
    ACC_DATA8,
    ACC_DATA16,
    ACC_DATA23
  } acc_kind_t;

  // external bus sequencer states
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_DATA
  } bus_state_t;

endpackage : pin_mux_pkg

// >>> rtl/pin_sync.sv
// two-flop synchroniser bank for pad inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // pad side and clean side
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          meta_q[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_q[i]   <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule : pin_sync

// >>> rtl/port_pin_and_ext_bus_mux.sv
// port pins, alternate functions and multiplexed external memory bus
`timescale 1ns/1ns
module port_pin_and_ext_bus_mux
  import pin_mux_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // port output latches and control bits from the core
  input  wire logic [7:0]              p0_latch,
  input  wire logic [7:0]              p1_latch,
  input  wire logic [7:0]              port2_output_latch,
  input  wire logic [7:0]              p3_latch,
  input  wire logic [7:0]              spi_control_reg,
  input  wire logic [7:0]              aux_function_reg,
  input  wire logic                    ext_instr_active,
  // external access request from the core
  input  wire logic                    acc_req,
  input  pin_mux_pkg::acc_kind_t       acc_kind,
  input  wire logic [22:0]             acc_addr,
  input  wire logic                    acc_write,
  input  wire logic [7:0]              acc_wdata,
  output logic                         acc_done,
  output logic [7:0]                   acc_rdata,
  // peripheral outputs to be routed
  input  wire logic                    timer2_clkout_en,
  input  wire logic                    timer2_clkout,
  input  wire logic [4:0]              pca_out_en,
  input  wire logic [4:0]              pca_out,
  input  wire logic                    serial0_transmit,
  input  wire logic                    spi_mosi_out,
  input  wire logic                    spi_mosi_oe,
  input  wire logic                    spi_clk_out,
  input  wire logic                    spi_clk_oe,
  // synchronised pin levels to the core and peripherals
  output logic [7:0]                   p0_pin,
  output logic [7:0]                   p1_pin,
  output logic [7:0]                   p2_pin,
  output logic [7:0]                   p3_pin,
  output logic                         timer2_count_io,
  output logic                         timer2_aux_input,
  output logic                         pca_ext_clock_in,
  output logic [4:0]                   pca_pin_in,
  output logic                         serial0_receive,
  output logic                         ext_irq_zero,
  output logic                         ext_irq_one,
  // pads
  input  wire logic [31:0]             pad_in,
  output logic [7:0]                   p0_out,
  output logic [7:0]                   p0_oe,
  output logic [7:0]                   p1_out,
  output logic [7:0]                   p1_oe,
  output logic [7:0]                   p1_pullup,
  output logic [7:0]                   p2_out,
  output logic [7:0]                   p2_oe,
  output logic [7:0]                   p2_pullup,
  output logic [7:0]                   p3_out,
  output logic [7:0]                   p3_oe,
  output logic [7:0]                   p3_pullup,
  output logic                         ale
);

  import pin_mux_pkg::*;

  // quasi-bidirectional drive: a zero pulls low hard, a one rides the pull-up
  function automatic logic [15:0] quasi_drive(input logic [7:0] v);
    quasi_drive = {v, ~v}; // {pullup, oe}
  endfunction : quasi_drive

  // pad synchronisation
  logic [31:0] pin_s;

  pin_sync #(.W(PIN_TOTAL)) u_pin_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (pad_in),
    .sync_out (pin_s)
  );

  // pin read-back and alternate inputs straight from the sync flops
  assign p0_pin           = pin_s[P0_LSB +: PORT_W];
  assign p1_pin           = pin_s[P1_LSB +: PORT_W];
  assign p2_pin           = pin_s[P2_LSB +: PORT_W];
  assign p3_pin           = pin_s[P3_LSB +: PORT_W];
  assign timer2_count_io  = pin_s[P1_LSB + T2_BIT];
  assign timer2_aux_input = pin_s[P1_LSB + T2AUX_BIT];
  assign pca_ext_clock_in = pin_s[P1_LSB + ECI_BIT];
  assign pca_pin_in       = pin_s[P1_LSB + PCA_BASE_BIT +: PCA_MODULES];
  assign serial0_receive  = pin_s[P3_LSB + RX0_BIT];
  assign ext_irq_zero     = pin_s[P3_LSB + IRQ0_BIT];
  assign ext_irq_one      = pin_s[P3_LSB + IRQ1_BIT];

  // ---------------- bus sequencer ----------------
  logic [2:0]  phase_q, phase_d;
  bus_state_t  st_q, st_d;
  acc_kind_t   kind_q, kind_d;
  logic [22:0] addr_q, addr_d;
  logic        wr_q, wr_d;
  logic [7:0]  wdata_q, wdata_d;
  logic        done_q, done_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        ale_q, ale_d;
  logic        busy_d;

  // requests are only taken at a machine cycle boundary, so every bus
  // cycle starts on phase 0 and the strobe stays at a fixed rate
  always_comb begin
    phase_d = (phase_q == PHASE_LAST) ? PHASE_RESET : phase_q + 3'h1;
    st_d    = st_q;
    kind_d  = kind_q;
    addr_d  = addr_q;
    wr_d    = wr_q;
    wdata_d = wdata_q;
    done_d  = 1'b0;
    case (st_q)
      BUS_IDLE: begin
        if (phase_q == PHASE_LAST && acc_req) begin
          st_d    = BUS_ADDR;
          kind_d  = acc_kind;
          addr_d  = acc_addr;
          wr_d    = acc_write && (acc_kind != ACC_CODE);
          wdata_d = acc_wdata;
        end
      end
      BUS_ADDR: begin
        if (phase_q == PHASE_LAST) begin
          // code fetch ends here; data access takes a second machine cycle
          st_d   = (kind_q == ACC_CODE) ? BUS_IDLE : BUS_DATA;
          done_d = (kind_q == ACC_CODE);
        end
      end
      BUS_DATA: begin
        if (phase_q == PHASE_LAST) begin
          st_d   = BUS_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        st_d = BUS_IDLE;
      end
    endcase
    // read data is what the pins show on the last phase (two clocks of sync lag)
    rdata_d = (done_d && !wr_q) ? pin_s[P0_LSB +: PORT_W] : rdata_q;
    busy_d  = (st_d != BUS_IDLE);
    // data machine cycle has no strobe: the skipped pulse
    ale_d   = (phase_d <= ALE_LAST_PHASE) && (st_d != BUS_DATA)
              && (!aux_function_reg[ALE_OFF_BIT] || ext_instr_active);
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_q <= PHASE_RESET;
      st_q    <= BUS_IDLE;
      kind_q  <= ACC_CODE;
      addr_q  <= '0;
      wr_q    <= 1'b0;
      wdata_q <= DRIVE_NONE;
      done_q  <= 1'b0;
      rdata_q <= DRIVE_NONE;
      ale_q   <= 1'b0;
    end else begin
      phase_q <= phase_d;
      st_q    <= st_d;
      kind_q  <= kind_d;
      addr_q  <= addr_d;
      wr_q    <= wr_d;
      wdata_q <= wdata_d;
      done_q  <= done_d;
      rdata_q <= rdata_d;
      ale_q   <= ale_d;
    end
  end

  assign acc_done  = done_q;
  assign acc_rdata = rdata_q;
  assign ale       = ale_q;

  // ---------------- pad drivers ----------------
  logic [7:0]  p0_out_q, p0_out_d, p0_oe_q, p0_oe_d;
  logic [7:0]  p1_out_q, p1_out_d, p1_oe_q, p1_oe_d, p1_pu_q, p1_pu_d;
  logic [7:0]  p2_out_q, p2_out_d, p2_oe_q, p2_oe_d, p2_pu_q, p2_pu_d;
  logic [7:0]  p3_out_q, p3_out_d, p3_oe_q, p3_oe_d, p3_pu_q, p3_pu_d;
  logic [7:0]  p1_val, p3_val;

  // drivers are computed from the next sequencer state so pads and strobe
  // change on the same edge; memory latches address as the strobe falls
  always_comb begin
    // port 0: open drain as a port, push-pull as the bus
    p0_out_d = DRIVE_NONE;
    p0_oe_d  = ~p0_latch;
    if (busy_d) begin
      p0_oe_d = DRIVE_NONE;                                 // read turnaround floats
      if (st_d == BUS_ADDR && phase_d <= ALE_LAST_PHASE) begin
        p0_out_d = addr_d[7:0];
        p0_oe_d  = DRIVE_ALL;
      end else if (st_d == BUS_DATA && wr_d) begin
        p0_out_d = wdata_d;
        p0_oe_d  = DRIVE_ALL;
      end
    end
    // port 1: timer 2 and counter array outputs are ANDed with the latch, idle high
    p1_val = p1_latch;
    p1_val[T2_BIT] = p1_latch[T2_BIT] & (~timer2_clkout_en | timer2_clkout);
    for (int i = 0; i < PCA_MODULES; i++) begin
      p1_val[PCA_BASE_BIT + i] = p1_latch[PCA_BASE_BIT + i]
                                 & (~pca_out_en[i] | pca_out[i]);
    end
    {p1_pu_d, p1_oe_d} = quasi_drive(p1_val);
    p1_out_d = DRIVE_NONE;
    if (spi_control_reg[SPI_EN_BIT]) begin
      p1_out_d[MOSI_BIT] = spi_mosi_out;
      p1_oe_d[MOSI_BIT]  = spi_mosi_oe;
      p1_pu_d[MOSI_BIT]  = 1'b0;
      p1_out_d[SCK_BIT]  = spi_clk_out;
      p1_oe_d[SCK_BIT]   = spi_clk_oe;
      p1_pu_d[SCK_BIT]   = 1'b0;
    end
    // port 2: high address byte unless an 8-bit indirect access
    {p2_pu_d, p2_oe_d} = quasi_drive(port2_output_latch);
    p2_out_d = DRIVE_NONE;
    if (busy_d && kind_d != ACC_DATA8) begin
      p2_oe_d = DRIVE_ALL;
      p2_pu_d = DRIVE_NONE;
      if (kind_d == ACC_DATA23) begin
        p2_out_d = {addr_d[15], ale_d ? addr_d[22:16] : addr_d[14:8]};
      end else begin
        p2_out_d = addr_d[15:8];
      end
    end
    // port 3: serial transmit shares the latch AND
    p3_val = p3_latch;
    p3_val[TX0_BIT] = p3_latch[TX0_BIT] & serial0_transmit;
    {p3_pu_d, p3_oe_d} = quasi_drive(p3_val);
    p3_out_d = DRIVE_NONE;
  end

  // pad registers; reset releases every port, ports 1-3 onto their pull-ups and port 0 floating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      p0_out_q <= DRIVE_NONE;
      p0_oe_q  <= DRIVE_NONE;
      p1_out_q <= DRIVE_NONE;
      p1_oe_q  <= DRIVE_NONE;
      p1_pu_q  <= PORT_RESET;
      p2_out_q <= DRIVE_NONE;
      p2_oe_q  <= DRIVE_NONE;
      p2_pu_q  <= PORT_RESET;
      p3_out_q <= DRIVE_NONE;
      p3_oe_q  <= DRIVE_NONE;
      p3_pu_q  <= PORT_RESET;
    end else begin
      p0_out_q <= p0_out_d;
      p0_oe_q  <= p0_oe_d;
      p1_out_q <= p1_out_d;
      p1_oe_q  <= p1_oe_d;
      p1_pu_q  <= p1_pu_d;
      p2_out_q <= p2_out_d;
      p2_oe_q  <= p2_oe_d;
      p2_pu_q  <= p2_pu_d;
      p3_out_q <= p3_out_d;
      p3_oe_q  <= p3_oe_d;
      p3_pu_q  <= p3_pu_d;
    end
  end

  assign p0_out    = p0_out_q;
  assign p0_oe     = p0_oe_q;
  assign p1_out    = p1_out_q;
  assign p1_oe     = p1_oe_q;
  assign p1_pullup = p1_pu_q;
  assign p2_out    = p2_out_q;
  assign p2_oe     = p2_oe_q;
  assign p2_pullup = p2_pu_q;
  assign p3_out    = p3_out_q;
  assign p3_oe     = p3_oe_q;
  assign p3_pullup = p3_pu_q;

  // ---------------- checks ----------------
  a_p0_open_drain: assert property (@(posedge clk) disable iff (!rst_n)
    !busy_d |=> (p0_oe_q == ~$past(p0_latch)) && (p0_out_q == DRIVE_NONE))
    else $error("port 0 not open drain outside bus cycle");

  a_p0_addr_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == BUS_ADDR && phase_q == PHASE_RESET)
      |-> (p0_oe_q == DRIVE_ALL) && (p0_out_q == addr_q[7:0]))
    else $error("port 0 does not drive low address");

  a_p2_quasi_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !busy_d |=> (p2_pu_q == $past(port2_output_latch)) && (p2_oe_q == ~p2_pu_q))
    else $error("port 2 pull-up does not follow latch");

  a_p2_high_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q != BUS_IDLE && (kind_q == ACC_DATA16 || kind_q == ACC_CODE))
      |-> (p2_oe_q == DRIVE_ALL) && (p2_out_q == addr_q[15:8]))
    else $error("port 2 does not drive high address");

  a_p2_keeps_latch: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q != BUS_IDLE && kind_q == ACC_DATA8) |-> (p2_oe_q == ~$past(port2_output_latch)))
    else $error("port 2 left its latch during 8-bit access");

  a_p2_wide_phase: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q != BUS_IDLE && kind_q == ACC_DATA23)
      |-> (p2_out_q[6:0] == (ale_q ? addr_q[22:16] : addr_q[14:8])))
    else $error("port 2 wide address phasing wrong");

  a_p2_bit7_a15: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q != BUS_IDLE && kind_q == ACC_DATA23) |-> (p2_out_q[7] == addr_q[15]))
    else $error("port 2 bit 7 does not carry A15");

  a_spi_mosi_pin: assert property (@(posedge clk) disable iff (!rst_n)
    spi_control_reg[SPI_EN_BIT]
      |=> !p1_pu_q[MOSI_BIT] && (p1_out_q[MOSI_BIT] == $past(spi_mosi_out)))
    else $error("mosi pin not taken over");

  a_spi_clk_pin: assert property (@(posedge clk) disable iff (!rst_n)
    spi_control_reg[SPI_EN_BIT]
      |=> !p1_pu_q[SCK_BIT] && (p1_oe_q[SCK_BIT] == $past(spi_clk_oe)))
    else $error("spi clock pin not taken over");

  a_mc_six_clocks: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_q == PHASE_RESET) |=> (phase_q != PHASE_RESET) [*5] ##1 (phase_q == PHASE_RESET))
    else $error("machine cycle is not six clocks");

  // the strobe register has no pulse in the first phase after reset, and the
  // inhibit bit acts with one clock of lag, so both pulse phases must be free of it
  a_ale_rate_skip: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_q == PHASE_RESET && st_q != BUS_DATA && $past(rst_n)
      && (!$past(aux_function_reg[ALE_OFF_BIT]) || $past(ext_instr_active))
      && (!aux_function_reg[ALE_OFF_BIT] || ext_instr_active))
      |-> ale_q ##1 ale_q ##1 !ale_q [*4])
    else $error("strobe pulse missing or wrong width");

  a_ale_inhibit: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(aux_function_reg[ALE_OFF_BIT]) && !$past(ext_instr_active)) |-> !ale_q)
    else $error("strobe not suppressed");

endmodule : port_pin_and_ext_bus_mux

// >>> verification/ext_memory_model.sv
// external memory model with a transparent address latch on the multiplexed bus
`timescale 1ns/1ns
module ext_memory_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // bus pins as seen on the board
  input  wire logic        ale,
  input  wire logic [7:0]  p0_pad,
  input  wire logic [7:0]  p2_pad,
  input  wire logic [7:0]  p0_oe,
  // read drive and last write seen
  output logic             mem_drive,
  output logic [7:0]       mem_data,
  output logic [22:0]      wr_addr,
  output logic [7:0]       wr_data
);
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  logic [7:0] mid_q;
  logic       ale_q;
  logic       ok_q;

  // the latch follows the bus while the strobe is high, so it keeps what stood at its fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ok_q    <= 1'b0;
      ale_q   <= 1'b0;
      wr_addr <= 23'h000000;
      wr_data <= 8'h00;
    end else begin
      ale_q <= ale;
      if (ale) begin
        lo_q <= p0_pad;
        hi_q <= p2_pad;
        ok_q <= 1'b1;
      end
      if (!ale && ale_q) mid_q <= p2_pad;
      // a fully driven bus after the address phase carries write data
      if (!ale && ok_q && p0_oe == 8'hFF) begin
        wr_addr <= {hi_q[6:0], mid_q, lo_q};
        wr_data <= p0_pad;
      end
    end
  end

  // slow memory: answers only once the device has let go of the bus
  assign mem_drive = !ale && ok_q && p0_oe == 8'h00;
  assign mem_data  = lo_q + mid_q;
endmodule : ext_memory_model

// >>> verification/test_port_pin_and_ext_bus_mux.sv
// self-checking bench for the port pin and external bus multiplexer
`timescale 1ns/1ns
module test_port_pin_and_ext_bus_mux;
  import pin_mux_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ext_instr_active = 1'b0;
  logic [7:0] p0_latch = 8'hFF, p1_latch = 8'hFF, port2_output_latch = 8'hFF;
  logic [7:0] p3_latch = 8'hFF, spi_control_reg = 8'h00, aux_function_reg = 8'h00;
  logic acc_req = 1'b0, acc_write = 1'b0, timer2_clkout_en = 1'b0, timer2_clkout = 1'b0;
  acc_kind_t acc_kind = ACC_CODE;
  logic [22:0] acc_addr = 23'h000000;
  logic [7:0] acc_wdata = 8'h00;
  logic [4:0] pca_out_en = 5'h00, pca_out = 5'h00;
  logic serial0_transmit = 1'b1, spi_mosi_out = 1'b0, spi_mosi_oe = 1'b0;
  logic spi_clk_out = 1'b0, spi_clk_oe = 1'b0;
  logic [7:0] p1_en = 8'h00, p1_val = 8'h00, p3_en = 8'h00, p3_val = 8'h00;
  logic [7:0] float_q = 8'h5A;
  logic acc_done, ale, timer2_count_io, timer2_aux_input, pca_ext_clock_in;
  logic serial0_receive, ext_irq_zero, ext_irq_one, mem_drive;
  logic [4:0] pca_pin_in;
  logic [7:0] acc_rdata, p0_out, p0_oe, p1_out, p1_oe, p1_pullup, p2_out, p2_oe;
  logic [7:0] p2_pullup, p3_out, p3_oe, p3_pullup, p0_pad, p2_pad, mem_data, wr_data;
  logic [22:0] wr_addr;
  logic [31:0] pad_in;
  logic [7:0] p0_pin, p1_pin, p2_pin, p3_pin;
  logic ale_h[48];
  logic [7:0] p0o_h[48], p0e_h[48], p2o_h[48], p2e_h[48];
  int done_at, n_fail = 0, checks_done = 0;

  // a quasi pin: driven, else held by the board, else pulled up, else floating
  function automatic logic [7:0] quasi(input logic [7:0] oe, out, pu, en, val);
    return (oe & out) | (~oe & en & val) | (~oe & ~en & pu) | (~oe & ~en & ~pu & float_q);
  endfunction : quasi

  // port 0 has no pull-up, so an undriven pin shows a changing pattern
  assign p0_pad = (p0_oe & p0_out) | (~p0_oe & (mem_drive ? mem_data : float_q));
  assign p2_pad = quasi(p2_oe, p2_out, p2_pullup, 8'h00, 8'h00);
  assign pad_in = {quasi(p3_oe, p3_out, p3_pullup, p3_en, p3_val), p2_pad,
                   quasi(p1_oe, p1_out, p1_pullup, p1_en, p1_val), p0_pad};

  port_pin_and_ext_bus_mux port_pin_and_ext_bus_mux_i (
    .clk, .rst_n, .p0_latch, .p1_latch, .port2_output_latch, .p3_latch,
    .spi_control_reg, .aux_function_reg, .ext_instr_active, .acc_req, .acc_kind,
    .acc_addr, .acc_write, .acc_wdata, .acc_done, .acc_rdata, .timer2_clkout_en,
    .timer2_clkout, .pca_out_en, .pca_out, .serial0_transmit, .spi_mosi_out,
    .spi_mosi_oe, .spi_clk_out, .spi_clk_oe, .p0_pin, .p1_pin, .p2_pin,
    .p3_pin, .timer2_count_io, .timer2_aux_input, .pca_ext_clock_in, .pca_pin_in,
    .serial0_receive, .ext_irq_zero, .ext_irq_one, .pad_in, .p0_out, .p0_oe,
    .p1_out, .p1_oe, .p1_pullup, .p2_out, .p2_oe, .p2_pullup, .p3_out, .p3_oe,
    .p3_pullup, .ale
  );

  ext_memory_model ext_memory_model_i (
    .clk, .rst_n, .ale, .p0_pad, .p2_pad, .p0_oe, .mem_drive, .mem_data, .wr_addr,
    .wr_data
  );

  // clock and floating-pin pattern
  always #20 clk = ~clk;
  always @(posedge clk) float_q <= ~float_q;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop;
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // holds the request until done, keeping a per-cycle history of the bus pins
  task automatic run_acc(input acc_kind_t kind, input logic [22:0] addr, input logic wr,
                         input logic [7:0] wd);
    int k;
    k = 0;
    done_at = -1;
    acc_kind = kind;
    acc_addr = addr;
    acc_write = wr;
    acc_wdata = wd;
    acc_req = 1'b1;
    while (done_at < 0 && k < 40) begin
      @(negedge clk);
      ale_h[k] = ale;
      p0o_h[k] = p0_out;
      p0e_h[k] = p0_oe;
      p2o_h[k] = p2_out;
      p2e_h[k] = p2_oe;
      if (acc_done === 1'b1) done_at = k;
      k++;
    end
    acc_req = 1'b0;
    if (done_at < 0) begin
      chk("acc_done wait", 0, 1);
      report_and_stop();
    end
  endtask : run_acc

  task automatic idle_ports;
    p0_latch = 8'h0F;
    p1_latch = 8'hC3;
    port2_output_latch = 8'h3C;
    p3_latch = 8'h96;
    tick(2);
    chk("p0 idle", {p0_oe, p0_out}, 16'hF000);
    chk("p1 idle", {p1_oe, p1_out, p1_pullup}, 24'h3C00C3);
    chk("p2 idle", {p2_oe, p2_out, p2_pullup}, 24'hC3003C);
    chk("p3 idle", {p3_oe, p3_out, p3_pullup}, 24'h690096);
    p0_latch = 8'hFF;
    p1_latch = 8'hFF;
    port2_output_latch = 8'hFF;
    p3_latch = 8'hFF;
  endtask : idle_ports

  task automatic ale_rate;
    int c;
    c = 0;
    for (int i = 0; i < 24; i++) begin
      @(negedge clk);
      ale_h[i] = ale;
      c += ale;
    end
    chk("ale pulses", c, 8);
    for (int i = 0; i < 18; i++) chk("ale period", ale_h[i], ale_h[i + 6]);
  endtask : ale_rate

  task automatic code_fetch;
    int b;
    run_acc(ACC_CODE, 23'h00F2A7, 1'b0, 8'h00);
    // done shows one clock after the last phase, so the strobe cycle is six back
    chk("code latency", done_at >= 6, 1);
    b = (done_at >= 6) ? done_at - 6 : 0;
    chk("code ale", {ale_h[b], ale_h[b+1], ale_h[b+2], ale_h[b+5]}, 4'hC);
    chk("code p0 addr", {p0e_h[b], p0o_h[b]}, 16'hFFA7);
    chk("code p0 float", p0e_h[b+2], 8'h00);
    chk("code p2 addr", {p2e_h[b], p2o_h[b]}, 16'hFFF2);
    chk("code rdata", acc_rdata, 8'h99);
    tick(8);
  endtask : code_fetch

  // one data access; hi and lo are port 2 with the strobe high and low
  task automatic data_acc(input acc_kind_t kind, input logic [22:0] addr, input logic wr,
                          input logic [7:0] wd, hi, lo, p2e, rd);
    int b;
    run_acc(kind, addr, wr, wd);
    chk("data latency", done_at >= 12, 1);
    b = (done_at >= 12) ? done_at - 12 : 0;
    chk("data ale", {ale_h[b], ale_h[b+1], ale_h[b+2]}, 3'h6);
    for (int i = 6; i < 12; i++) chk("ale skip", ale_h[b+i], 1'b0);
    chk("data p0 addr", {p0e_h[b], p0o_h[b]}, {8'hFF, addr[7:0]});
    chk("p2 ale high", {p2e_h[b], p2o_h[b]}, {p2e, hi});
    chk("p2 ale low", p2o_h[b+2], lo);
    chk("p0 data oe", p0e_h[b+6], wr ? 8'hFF : 8'h00);
    if (wr) begin
      chk("p0 wdata", p0o_h[b+6], wd);
      tick(1);
      chk("mem addr", wr_addr, addr);
      chk("mem data", wr_data, wd);
    end else begin
      chk("data rdata", acc_rdata, rd);
    end
    tick(8);
  endtask : data_acc

  task automatic ale_inhibit;
    int c;
    aux_function_reg = 8'hFE;
    tick(2);
    for (int k = 0; k < 3; k++) begin
      c = 0;
      for (int i = 0; i < 12; i++) begin
        @(negedge clk);
        c += ale;
      end
      chk("ale inhibit", c, (k == 1) ? 0 : 4);
      aux_function_reg = 8'h01;
      ext_instr_active = (k == 1);
      tick(2);
    end
    aux_function_reg = 8'h00;
    ext_instr_active = 1'b0;
  endtask : ale_inhibit

  task automatic spi_takeover;
    spi_mosi_out = 1'b1;
    spi_mosi_oe = 1'b1;
    spi_clk_oe = 1'b1;
    spi_control_reg = 8'hBF;
    tick(2);
    chk("spi bit clear", {p1_oe, p1_pullup}, 16'h00FF);
    spi_control_reg = 8'h40;
    tick(2);
    chk("spi pins", {p1_oe[5:4], p1_out[5:4], p1_pullup}, 12'hDCF);
    spi_mosi_oe = 1'b0;
    tick(2);
    chk("mosi released", {p1_oe[4], p1_pullup[4]}, 2'h0);
    spi_control_reg = 8'h00;
    tick(2);
    chk("spi off", p1_pullup, 8'hFF);
  endtask : spi_takeover

  task automatic alt_outputs;
    timer2_clkout_en = 1'b1;
    pca_out_en = 5'h15;
    serial0_transmit = 1'b0;
    tick(2);
    chk("alt low", {p1_oe, p1_out, p3_oe, p3_out}, 32'hA9000200);
    timer2_clkout = 1'b1;
    pca_out = 5'h1F;
    serial0_transmit = 1'b1;
    tick(2);
    chk("alt high", {p1_oe, p1_pullup, p3_oe}, 24'h00FF00);
    p1_latch = 8'hFE;
    tick(2);
    chk("alt and latch", p1_oe, 8'h01);
    p1_latch = 8'hFF;
    timer2_clkout_en = 1'b0;
    pca_out_en = 5'h00;
  endtask : alt_outputs

  task automatic alt_inputs;
    p1_en = 8'hFF;
    p3_en = 8'h0D;
    p0_latch = 8'h00; // port 0 pulls its pins low, port 2 rides its pull-ups
    for (int k = 0; k < 2; k++) begin
      p1_val = k ? 8'h59 : 8'hA6;
      p3_val = k ? 8'h04 : 8'h09;
      tick(4);
      chk("p1 inputs", {pca_pin_in, pca_ext_clock_in, timer2_aux_input, timer2_count_io},
          p1_val);
      chk("p3 inputs", {ext_irq_one, ext_irq_zero, serial0_receive},
          {p3_val[3], p3_val[2], p3_val[0]});
      chk("pin levels", {p0_pin, p1_pin, p2_pin, p3_pin},
          {8'h00, p1_val, 8'hFF, (p3_val & p3_en) | ~p3_en});
    end
    p0_latch = 8'hFF;
    p1_en = 8'h00;
    p3_en = 8'h00;
  endtask : alt_inputs

  // main sequence: reset for three edges, then one task per scenario
  initial begin
    tick(2);
    chk("reset oe", {p0_oe, p1_oe, p2_oe, p3_oe}, 32'h00000000);
    chk("reset pullups", {p1_pullup, p2_pullup, p3_pullup, ale, acc_done}, 26'h3FFFFFC);
    tick(1);
    rst_n = 1'b1;
    idle_ports();
    ale_rate();
    code_fetch();
    data_acc(ACC_DATA23, 23'h2DB56C, 1'b1, 8'h93, 8'hAD, 8'hB5, 8'hFF, 8'h00);
    data_acc(ACC_DATA23, 23'h4A3C01, 1'b0, 8'h00, 8'h4A, 8'h3C, 8'hFF, 8'h3D);
    data_acc(ACC_DATA16, 23'h00ABCD, 1'b0, 8'h00, 8'hAB, 8'hAB, 8'hFF, 8'h78);
    port2_output_latch = 8'h5A;
    data_acc(ACC_DATA8, 23'h000077, 1'b0, 8'h00, 8'h00, 8'h00, 8'hA5, 8'hD1);
    port2_output_latch = 8'hFF;
    ale_inhibit();
    spi_takeover();
    alt_outputs();
    alt_inputs();
    report_and_stop();
  end
endmodule : test_port_pin_and_ext_bus_mux
